// [src/albx_exec.sv]
// execution datapath for arithmetic, logic and branch instructions
`timescale 1ns/100ps
module albx_exec (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic issue_valid,
    input wire albx_pkg::albx_issue_t issue,
    input wire logic [7:0] io_rd_data,
    input wire logic [7:0] io_w1c_mask,
    output logic issue_ready,
    output albx_pkg::albx_wb_t wb,
    output logic [7:0] sreg,
    output logic [15:0] pc,
    output logic io_addr_err
);
    import albx_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WORD = 4'b0010,
        ST_FLOW = 4'b0100,
        ST_CALL = 4'b1000
    } albx_state_t;

    albx_state_t state_r, state_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic [7:0] sreg_r, sreg_nxt;
    logic [15:0] pc_r, pc_nxt;
    logic [15:0] tgt_r, tgt_nxt;
    albx_wb_t wb_r, wb_nxt;
    logic err_r, err_nxt;

    logic [7:0] a8, b8, r8;
    logic cin8, sub8, c8, z8, n8, v8, h8;
    logic [15:0] r16;
    logic c16, z16, n16, v16, h16_unused;
    logic [7:0] logic_res;
    logic [7:0] io_mod;
    logic take;

    // byte arithmetic lane
    albx_flag_calc #(.W(8)) u_byte (
        .a(a8), .b(b8), .cin(cin8), .sub(sub8),
        .res(r8), .c(c8), .z(z8), .n(n8), .v(v8), .h(h8)
    );

    // word lane: register pair against a zero-extended constant
    albx_flag_calc #(.W(16)) u_word (
        .a({issue.rd_hi_val, issue.rd_val}), .b({8'h00, issue.imm}), .cin(1'b0),
        .sub(issue.op == ALBX_OP_WORD_IMMEDIATE_MINUS),
        .res(r16), .c(c16), .z(z16), .n(n16), .v(v16), .h(h16_unused)
    );

    assign take = issue_valid & issue_ready;
    assign issue_ready = (state_r == ST_IDLE);

    // operand select for the byte lane
    always_comb begin
        a8 = issue.rd_val;
        b8 = issue.rr_val;
        cin8 = 1'b0;
        sub8 = 1'b0;
        unique case (issue.op)
            ALBX_OP_ADC: cin8 = sreg_r[ALBX_C];
            ALBX_OP_SUB: sub8 = 1'b1;
            ALBX_OP_MINUS_CONSTANT: begin
                sub8 = 1'b1;
                b8 = issue.imm;
            end
            ALBX_OP_MINUS_WITH_BORROW_REGS: begin
                sub8 = 1'b1;
                cin8 = sreg_r[ALBX_C];
            end
            ALBX_OP_MINUS_BORROW_CONSTANT: begin
                sub8 = 1'b1;
                cin8 = sreg_r[ALBX_C];
                b8 = issue.imm;
            end
            default: ;
        endcase
    end

    // logic lane
    always_comb begin
        unique case (issue.op)
            ALBX_OP_AND: logic_res = issue.rd_val & issue.rr_val;
            ALBX_OP_ANDI: logic_res = issue.rd_val & issue.imm;
            ALBX_OP_OR: logic_res = issue.rd_val | issue.rr_val;
            ALBX_OP_ORI: logic_res = issue.rd_val | issue.imm;
            ALBX_OP_EXCLUSIVE_OR_REGS: logic_res = issue.rd_val ^ issue.rr_val;
            ALBX_OP_ZERO_SIGN_PROBE: logic_res = issue.rd_val & issue.rd_val;
            ALBX_OP_BIT_SET_MASK: logic_res = issue.rd_val | issue.imm;
            ALBX_OP_BIT_CLEAR_MASK: logic_res = issue.rd_val & (ALBX_ALL_ONES - issue.imm);
            default: logic_res = issue.rd_val;
        endcase
    end

    // io bit read-modify-write: whole register read, one bit changed
    always_comb begin
        io_mod = io_rd_data;
        if (issue.op == ALBX_OP_IO_BIT_SET_INSTR) begin
            io_mod[issue.bit_sel] = 1'b1;
        end else begin
            io_mod[issue.bit_sel] = 1'b0;
        end
        // flags read as one go back as one and so clear themselves
        io_mod = io_mod | (io_rd_data & io_w1c_mask);
    end

    // sequencing, flags, program counter and write-back
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        sreg_nxt = sreg_r;
        pc_nxt = pc_r;
        tgt_nxt = tgt_r;
        wb_nxt = '0;
        err_nxt = 1'b0;
        unique case (state_r)
            ST_IDLE: begin
                if (take) begin
                    pc_nxt = pc_r + ALBX_PC_STEP;
                    unique case (issue.op)
                        ALBX_OP_ADD, ALBX_OP_ADC, ALBX_OP_SUB, ALBX_OP_MINUS_CONSTANT,
                        ALBX_OP_MINUS_WITH_BORROW_REGS, ALBX_OP_MINUS_BORROW_CONSTANT: begin
                            // result and flags land at this edge for the next instruction
                            wb_nxt.rd_we = 1'b1;
                            wb_nxt.rd_data = r8;
                            sreg_nxt[ALBX_C] = c8;
                            // borrow forms keep zero only if it was already set
                            if (issue.op == ALBX_OP_MINUS_WITH_BORROW_REGS
                                    || issue.op == ALBX_OP_MINUS_BORROW_CONSTANT) begin
                                sreg_nxt[ALBX_Z] = z8 & sreg_r[ALBX_Z];
                            end else begin
                                sreg_nxt[ALBX_Z] = z8;
                            end
                            sreg_nxt[ALBX_N] = n8;
                            sreg_nxt[ALBX_V] = v8;
                            sreg_nxt[ALBX_S] = n8 ^ v8;
                            sreg_nxt[ALBX_H] = h8;
                        end
                        ALBX_OP_AND, ALBX_OP_ANDI, ALBX_OP_OR, ALBX_OP_ORI, ALBX_OP_EXCLUSIVE_OR_REGS,
                        ALBX_OP_ZERO_SIGN_PROBE, ALBX_OP_BIT_SET_MASK, ALBX_OP_BIT_CLEAR_MASK: begin
                            wb_nxt.rd_we = 1'b1;
                            wb_nxt.rd_data = logic_res;
                            // carry and half-carry stay as they are
                            sreg_nxt[ALBX_Z] = (logic_res == 8'h00);
                            sreg_nxt[ALBX_N] = logic_res[7];
                            sreg_nxt[ALBX_V] = 1'b0;
                            sreg_nxt[ALBX_S] = logic_res[7];
                        end
                        ALBX_OP_WORD_IMMEDIATE_PLUS, ALBX_OP_WORD_IMMEDIATE_MINUS: begin
                            wb_nxt.rd_we = 1'b1;
                            wb_nxt.rd_data = r16[7:0];
                            wb_nxt.rd_hi_we = 1'b1;
                            wb_nxt.rd_hi_data = r16[15:8];
                            sreg_nxt[ALBX_C] = c16;
                            sreg_nxt[ALBX_Z] = z16;
                            sreg_nxt[ALBX_N] = n16;
                            sreg_nxt[ALBX_V] = v16;
                            sreg_nxt[ALBX_S] = n16 ^ v16;
                            state_nxt = ST_WORD;
                            cnt_nxt = ALBX_WORD_CYCLES - 2'h1;
                        end
                        ALBX_OP_EQUAL_SKIP_COMPARE: begin
                            // equal costs one extra clock; no flag moves
                            if (issue.rd_val == issue.rr_val) begin
                                pc_nxt = pc_r + (issue.next_is_two_word ? ALBX_SKIP_TWO : ALBX_SKIP_ONE);
                                state_nxt = ST_FLOW;
                                cnt_nxt = 2'h1;
                                tgt_nxt = pc_nxt;
                            end
                        end
                        ALBX_OP_POINTER_JUMP: begin
                            tgt_nxt = issue.z_ptr;
                            pc_nxt = pc_r;
                            state_nxt = ST_FLOW;
                            cnt_nxt = ALBX_JUMP_CYCLES - 2'h1;
                        end
                        ALBX_OP_POINTER_SUBROUTINE_ENTRY: begin
                            wb_nxt.push_we = 1'b1;
                            wb_nxt.push_data = pc_r + ALBX_PC_STEP;
                            tgt_nxt = issue.z_ptr;
                            pc_nxt = pc_r;
                            state_nxt = ST_CALL;
                            cnt_nxt = ALBX_CALL_CYCLES - 2'h1;
                        end
                        ALBX_OP_IO_BIT_SET_INSTR, ALBX_OP_IO_BIT_CLEAR_INSTR: begin
                            // upper half of io space is refused, not written
                            if (issue.io_addr <= ALBX_IO_BIT_LAST) begin
                                wb_nxt.io_we = 1'b1;
                                wb_nxt.io_addr = issue.io_addr;
                                wb_nxt.io_data = io_mod;
                            end else begin
                                err_nxt = 1'b1;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            ST_WORD: begin
                cnt_nxt = cnt_r - 2'h1;
                if (cnt_r == 2'h1) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_FLOW, ST_CALL: begin
                cnt_nxt = cnt_r - 2'h1;
                if (cnt_r == 2'h1) begin
                    pc_nxt = tgt_r;
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    // state registers; clock enable freezes everything
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            cnt_r <= 2'h0;
            sreg_r <= ALBX_SREG_RST;
            pc_r <= ALBX_PC_RST;
            tgt_r <= ALBX_PC_RST;
            wb_r <= '0;
            err_r <= 1'b0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            sreg_r <= sreg_nxt;
            pc_r <= pc_nxt;
            tgt_r <= tgt_nxt;
            wb_r <= wb_nxt;
            err_r <= err_nxt;
        end
    end

    assign wb = wb_r;
    assign sreg = sreg_r;
    assign pc = pc_r;
    assign io_addr_err = err_r;
endmodule : albx_exec

// [src/albx_pkg.sv]
// package for the arithmetic, logic and branch execution datapath
package albx_pkg;
    localparam int ALBX_DW = 8;
    localparam int ALBX_PCW = 16;
    localparam logic [7:0] ALBX_ALL_ONES = 8'hff;
    localparam logic [5:0] ALBX_IO_BIT_LAST = 6'h1f;
    localparam logic [7:0] ALBX_SREG_RST = 8'h00;
    localparam logic [15:0] ALBX_PC_RST = 16'h0000;
    localparam logic [15:0] ALBX_SKIP_ONE = 16'h0002;
    localparam logic [15:0] ALBX_SKIP_TWO = 16'h0003;
    localparam logic [15:0] ALBX_PC_STEP = 16'h0001;
    localparam logic [1:0] ALBX_WORD_CYCLES = 2'h2;
    localparam logic [1:0] ALBX_JUMP_CYCLES = 2'h2;
    localparam logic [1:0] ALBX_CALL_CYCLES = 2'h3;
    // status register bit positions
    localparam int ALBX_C = 0;
    localparam int ALBX_Z = 1;
    localparam int ALBX_N = 2;
    localparam int ALBX_V = 3;
    localparam int ALBX_S = 4;
    localparam int ALBX_H = 5;

    typedef enum logic [4:0] {
        ALBX_OP_NOP = 5'h00, ALBX_OP_ADD = 5'h01, ALBX_OP_ADC = 5'h02,
        ALBX_OP_SUB = 5'h03, ALBX_OP_MINUS_CONSTANT = 5'h04,
        ALBX_OP_MINUS_WITH_BORROW_REGS = 5'h05, ALBX_OP_MINUS_BORROW_CONSTANT = 5'h06,
        ALBX_OP_AND = 5'h07, ALBX_OP_ANDI = 5'h08, ALBX_OP_OR = 5'h09, ALBX_OP_ORI = 5'h0a,
        ALBX_OP_EXCLUSIVE_OR_REGS = 5'h0b, ALBX_OP_ZERO_SIGN_PROBE = 5'h0c,
        ALBX_OP_BIT_SET_MASK = 5'h0d, ALBX_OP_BIT_CLEAR_MASK = 5'h0e,
        ALBX_OP_WORD_IMMEDIATE_PLUS = 5'h0f, ALBX_OP_WORD_IMMEDIATE_MINUS = 5'h10,
        ALBX_OP_EQUAL_SKIP_COMPARE = 5'h11, ALBX_OP_POINTER_JUMP = 5'h12,
        ALBX_OP_POINTER_SUBROUTINE_ENTRY = 5'h13, ALBX_OP_IO_BIT_SET_INSTR = 5'h14,
        ALBX_OP_IO_BIT_CLEAR_INSTR = 5'h15
    } albx_op_t;

    // one issued instruction from the decoder
    typedef struct packed {
        albx_op_t op;
        logic [7:0] rd_val;
        logic [7:0] rd_hi_val;
        logic [7:0] rr_val;
        logic [7:0] imm;
        logic [5:0] io_addr;
        logic [2:0] bit_sel;
        logic [15:0] z_ptr;
        logic next_is_two_word;
    } albx_issue_t;

    // results handed back to the register file and io space
    typedef struct packed {
        logic rd_we;
        logic [7:0] rd_data;
        logic rd_hi_we;
        logic [7:0] rd_hi_data;
        logic io_we;
        logic [5:0] io_addr;
        logic [7:0] io_data;
        logic push_we;
        logic [15:0] push_data;
    } albx_wb_t;
endpackage : albx_pkg

// [src/albx_flag_calc.sv]
// flag calculation for byte and word add and subtract
`timescale 1ns/100ps
module albx_flag_calc #(
    parameter int W = 8
) (
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    input wire logic cin,
    input wire logic sub,
    output logic [W-1:0] res,
    output logic c,
    output logic z,
    output logic n,
    output logic v,
    output logic h
);
    logic [W:0] full;
    logic [W-1:0] bx;

    // subtraction borrows: a - b - cin done as explicit difference
    always_comb begin
        bx = b;
        if (sub) begin
            full = {1'b0, a} - {1'b0, b} - {{W{1'b0}}, cin};
        end else begin
            full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
        end
        res = full[W-1:0];
        c = full[W];
        z = (res == '0);
        n = res[W-1];
        if (sub) begin
            v = (a[W-1] & ~bx[W-1] & ~res[W-1]) | (~a[W-1] & bx[W-1] & res[W-1]);
            h = (~a[3] & bx[3]) | (bx[3] & res[3]) | (res[3] & ~a[3]);
        end else begin
            v = (a[W-1] & bx[W-1] & ~res[W-1]) | (~a[W-1] & ~bx[W-1] & res[W-1]);
            h = (a[3] & bx[3]) | (bx[3] & ~res[3]) | (~res[3] & a[3]);
        end
    end
endmodule : albx_flag_calc

// [verif/albx_exec_checker.sv]
// assertions on the ports of the execution datapath
`timescale 1ns/100ps
module albx_exec_checker (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic issue_valid,
    input wire albx_pkg::albx_issue_t issue,
    input wire logic [7:0] io_rd_data,
    input wire logic [7:0] io_w1c_mask,
    input wire logic issue_ready,
    input wire albx_pkg::albx_wb_t wb,
    input wire logic [7:0] sreg,
    input wire logic [15:0] pc,
    input wire logic io_addr_err
);
    import albx_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // a take needs enable, valid and ready together
    wire logic take = clk_en && issue_valid && issue_ready;
    wire logic [7:0] bmask = 8'h01 << issue.bit_sel;
    sequence s_take(albx_op_t o);
        take && issue.op == o;
    endsequence
    property p_adc;
        s_take(ALBX_OP_ADC) |=> wb.rd_we && wb.rd_data == $past(issue.rd_val) + $past(issue.rr_val) + $past(sreg[0]);
    endproperty
    property p_word;
        s_take(ALBX_OP_WORD_IMMEDIATE_PLUS) |=> wb.rd_hi_we && !issue_ready
            && {wb.rd_hi_data, wb.rd_data} == {$past(issue.rd_hi_val), $past(issue.rd_val)} + $past(issue.imm);
    endproperty
    property p_clear;
        s_take(ALBX_OP_BIT_CLEAR_MASK) |=> wb.rd_data == ($past(issue.rd_val) & (ALBX_ALL_ONES - $past(issue.imm)));
    endproperty
    // immediate, probe and mask logic ops never disturb carry, and overflow is cleared
    property p_logic;
        take && issue.op inside {ALBX_OP_ANDI, ALBX_OP_ORI, ALBX_OP_ZERO_SIGN_PROBE, ALBX_OP_BIT_SET_MASK,
            ALBX_OP_BIT_CLEAR_MASK} |=> sreg[ALBX_C] == $past(sreg[ALBX_C]) && !sreg[ALBX_V];
    endproperty
    property p_skip;
        s_take(ALBX_OP_EQUAL_SKIP_COMPARE) ##0 (issue.rd_val == issue.rr_val && !issue.next_is_two_word)
            |=> pc == $past(pc) + ALBX_SKIP_ONE && sreg == $past(sreg) && !issue_ready;
    endproperty
    property p_jump;
        s_take(ALBX_OP_POINTER_JUMP) ##1 clk_en |-> !issue_ready ##1 pc == $past(issue.z_ptr, 2);
    endproperty
    property p_push;
        s_take(ALBX_OP_POINTER_SUBROUTINE_ENTRY) |=> wb.push_we && wb.push_data == $past(pc) + ALBX_PC_STEP;
    endproperty
    property p_call;
        s_take(ALBX_OP_POINTER_SUBROUTINE_ENTRY) ##1 clk_en ##1 clk_en |=> pc == $past(issue.z_ptr, 3);
    endproperty
    property p_io_range;
        take && (issue.op == ALBX_OP_IO_BIT_SET_INSTR || issue.op == ALBX_OP_IO_BIT_CLEAR_INSTR)
            && issue.io_addr > ALBX_IO_BIT_LAST |=> io_addr_err && !wb.io_we;
    endproperty
    property p_io_clr;
        s_take(ALBX_OP_IO_BIT_CLEAR_INSTR) ##0 issue.io_addr <= ALBX_IO_BIT_LAST |=> wb.io_we
            && wb.io_data == (($past(io_rd_data) & ~$past(bmask)) | ($past(io_rd_data) & $past(io_w1c_mask)));
    endproperty
    a_adc: assert property (p_adc) else $error("add with carry result wrong");
    a_word: assert property (p_word) else $error("word add wrong");
    a_clear: assert property (p_clear) else $error("mask clear wrong");
    a_logic: assert property (p_logic) else $error("logic op touched carry");
    a_skip: assert property (p_skip) else $error("equal skip wrong");
    a_jump: assert property (p_jump) else $error("pointer jump wrong");
    a_push: assert property (p_push) else $error("return address wrong");
    a_call: assert property (p_call) else $error("call target wrong");
    a_io_range: assert property (p_io_range) else $error("io address range wrong");
    a_io_clr: assert property (p_io_clr) else $error("io clear write wrong");
endmodule : albx_exec_checker

bind albx_exec albx_exec_checker u_chk (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .issue_valid(issue_valid),
    .issue(issue), .io_rd_data(io_rd_data), .io_w1c_mask(io_w1c_mask), .issue_ready(issue_ready), .wb(wb),
    .sreg(sreg), .pc(pc), .io_addr_err(io_addr_err));

// [verif/albx_io_model.sv]
// behavioural io register space behind the io bit instructions
`timescale 1ns/100ps
module albx_io_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [5:0] io_addr,
    input wire albx_pkg::albx_wb_t wb,
    output logic [7:0] io_rd_data,
    output logic [7:0] io_w1c_mask
);
    import albx_pkg::*;
    localparam logic [7:0] FLAG_MASK = 8'h80; // top bit of every register is a flag
    logic [7:0] mem_r [32];
    // unmapped space reads a pattern, never a stale register
    assign io_rd_data = (io_addr <= ALBX_IO_BIT_LAST) ? mem_r[io_addr[4:0]] : 8'h5a;
    assign io_w1c_mask = FLAG_MASK;
    // a one written to a flag clears it, a zero leaves it alone
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 32; i++) begin
                mem_r[i] <= FLAG_MASK;
            end
        end else if (wb.io_we) begin
            mem_r[wb.io_addr[4:0]] <= (wb.io_data & ~FLAG_MASK) | (mem_r[wb.io_addr[4:0]] & FLAG_MASK & ~wb.io_data);
        end
    end
endmodule : albx_io_model

// [verif/tb.sv]
// self-checking bench for the execution datapath
`timescale 1ns/100ps
module tb;
    import albx_pkg::*;
    logic clock;
    logic rst_n;
    logic clk_en;
    logic issue_valid;
    albx_issue_t issue;
    logic issue_ready;
    albx_wb_t wb;
    logic [7:0] sreg;
    logic [15:0] pc;
    logic io_addr_err;
    logic [7:0] io_rd_data;
    logic [7:0] io_w1c_mask;
    int mismatches;
    int checked;

    albx_exec uut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .issue_valid(issue_valid), .issue(issue),
        .io_rd_data(io_rd_data), .io_w1c_mask(io_w1c_mask), .issue_ready(issue_ready), .wb(wb), .sreg(sreg),
        .pc(pc), .io_addr_err(io_addr_err));
    albx_io_model io_space (.clock(clock), .rst_n(rst_n), .io_addr(issue.io_addr), .wb(wb),
        .io_rd_data(io_rd_data), .io_w1c_mask(io_w1c_mask));

    // core clock, 25 ns period
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    function automatic albx_issue_t mk(input albx_op_t o, input logic [7:0] rd, input logic [7:0] rr,
        input logic [7:0] imm);
        mk = '0;
        mk.op = o;
        mk.rd_val = rd;
        mk.rr_val = rr;
        mk.imm = imm;
    endfunction : mk

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    // valid stays up between calls so back-to-back issues need no gap;
    // ready only moves on the rising edge, so its value at the falling edge holds for the take
    task automatic go(input albx_issue_t i);
        @(negedge clock);
        issue = i;
        issue_valid = 1'b1;
        while (!issue_ready) begin
            @(negedge clock);
        end
        @(posedge clock);
        #1;
    endtask : go

    task automatic stop();
        @(negedge clock);
        issue_valid = 1'b0;
    endtask : stop

    task automatic t_arith();
        go(mk(ALBX_OP_ADD, 8'hff, 8'h01, 8'h00));
        go(mk(ALBX_OP_ADC, 8'h0f, 8'h70, 8'h00));
        check({wb.rd_we, wb.rd_data, sreg & 8'h2f}, 32'h1802c);
        go(mk(ALBX_OP_MINUS_CONSTANT, 8'h00, 8'h00, 8'h01));
        check({wb.rd_data, sreg & 8'h2f}, 32'hff25);
        go(mk(ALBX_OP_MINUS_WITH_BORROW_REGS, 8'h80, 8'h00, 8'h00));
        check({wb.rd_data, sreg & 8'h2f}, 32'h7f28);
        go(mk(ALBX_OP_MINUS_BORROW_CONSTANT, 8'h05, 8'h00, 8'h05));
        check({wb.rd_data, sreg & 8'h2f}, 32'h0000);
        stop();
    endtask : t_arith

    task automatic t_word();
        albx_issue_t i;
        i = mk(ALBX_OP_WORD_IMMEDIATE_PLUS, 8'hff, 8'h00, 8'h01);
        go(i);
        check({issue_ready, wb.rd_hi_we, wb.rd_hi_data, wb.rd_data, sreg & 8'h1f}, 32'h1010000);
        stop();
        @(posedge clock);
        #1;
        check(issue_ready, 1'b1);
        i = mk(ALBX_OP_WORD_IMMEDIATE_MINUS, 8'h00, 8'h00, 8'h01);
        go(i);
        check({wb.rd_hi_data, wb.rd_data, sreg & 8'h1f}, 32'hffff15);
        stop();
    endtask : t_word

    task automatic t_logic();
        albx_op_t ops [6];
        logic [7:0] a [6];
        logic [7:0] k [6];
        logic [7:0] r [6];
        logic [7:0] f [6];
        ops = '{ALBX_OP_ANDI, ALBX_OP_ORI, ALBX_OP_ZERO_SIGN_PROBE, ALBX_OP_BIT_SET_MASK, ALBX_OP_BIT_CLEAR_MASK,
            ALBX_OP_EXCLUSIVE_OR_REGS};
        a = '{8'hf0, 8'h80, 8'h9c, 8'h40, 8'h81, 8'h3c};
        k = '{8'h3c, 8'h01, 8'h00, 8'h02, 8'h81, 8'h00};
        r = '{8'h30, 8'h81, 8'h9c, 8'h42, 8'h00, 8'hff};
        f = '{8'h01, 8'h05, 8'h05, 8'h01, 8'h03, 8'h05};
        go(mk(ALBX_OP_ADD, 8'hff, 8'h01, 8'h00));
        // source operand is the inverse, so a probe that read it would show
        for (int j = 0; j < 6; j++) begin
            go(mk(ops[j], a[j], ~a[j], k[j]));
            check(sreg & 8'h0f, f[j]);
            check(wb.rd_data, r[j]);
        end
        stop();
    endtask : t_logic

    task automatic t_branch();
        albx_issue_t i;
        logic [15:0] pc0;
        logic [7:0] s0;
        logic [15:0] step [3];
        step = '{ALBX_SKIP_ONE, ALBX_SKIP_TWO, ALBX_PC_STEP};
        i = mk(ALBX_OP_EQUAL_SKIP_COMPARE, 8'h33, 8'h33, 8'h00);
        for (int j = 0; j < 3; j++) begin
            i.next_is_two_word = (j == 1);
            i.rr_val = (j == 2) ? 8'h34 : 8'h33;
            pc0 = pc;
            s0 = sreg;
            go(i);
            check({issue_ready, sreg, pc}, {j == 2, s0, pc0 + step[j]});
            stop();
            @(posedge clock);
            #1;
        end
        i = mk(ALBX_OP_POINTER_JUMP, 8'h00, 8'h00, 8'h00);
        i.z_ptr = 16'h1234;
        go(i);
        check(issue_ready, 1'b0);
        stop();
        @(posedge clock);
        #1;
        check({issue_ready, pc}, 32'h11234);
        i.op = ALBX_OP_POINTER_SUBROUTINE_ENTRY;
        i.z_ptr = 16'h0abc;
        go(i);
        check({wb.push_we, wb.push_data}, 32'h11235);
        stop();
        @(posedge clock);
        #1;
        check(issue_ready, 1'b0);
        @(posedge clock);
        #1;
        check({issue_ready, pc}, 32'h10abc);
    endtask : t_branch

    // clock enable low holds every register even with an issue offered
    task automatic t_freeze();
        logic [15:0] pc0;
        pc0 = pc;
        @(negedge clock);
        clk_en = 1'b0;
        issue = mk(ALBX_OP_ADD, 8'h01, 8'h01, 8'h00);
        issue_valid = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check({wb.rd_we, pc}, {1'b0, pc0});
        @(negedge clock);
        clk_en = 1'b1;
        @(posedge clock);
        #1;
        check({wb.rd_we, wb.rd_data, pc}, {1'b1, 8'h02, pc0 + ALBX_PC_STEP});
        stop();
    endtask : t_freeze

    task automatic t_io();
        albx_issue_t i;
        i = mk(ALBX_OP_IO_BIT_SET_INSTR, 8'h00, 8'h00, 8'h00);
        i.io_addr = 6'h0b;
        i.bit_sel = 3'h3;
        go(i);
        check({io_addr_err, wb.io_we, wb.io_addr, wb.io_data}, 32'h4b88);
        stop();
        @(posedge clock);
        #1;
        check(io_rd_data, 8'h08);
        i.op = ALBX_OP_IO_BIT_CLEAR_INSTR;
        i.io_addr = 6'h1f;
        i.bit_sel = 3'h0;
        go(i);
        check({io_addr_err, wb.io_we, wb.io_addr, wb.io_data}, 32'h5f80);
        i.io_addr = 6'h20;
        go(i);
        check({io_addr_err, wb.io_we}, 2'b10);
        stop();
    endtask : t_io

    task automatic report_and_stop();
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    // main sequence: reset for five cycles, then the scenarios
    initial begin
        mismatches = 0;
        checked = 0;
        rst_n = 1'b0;
        issue_valid = 1'b0;
        clk_en = 1'b1;
        issue = mk(ALBX_OP_NOP, 8'h00, 8'h00, 8'h00);
        repeat (5) @(posedge clock);
        @(negedge clock);
        check({issue_ready, sreg, pc}, {1'b1, ALBX_SREG_RST, ALBX_PC_RST});
        rst_n = 1'b1;
        t_arith();
        t_word();
        t_logic();
        t_branch();
        t_freeze();
        t_io();
        report_and_stop();
    end

    // the scenarios need under a hundred cycles; this cuts a hang short
    initial begin
        #20000;
        mismatches++;
        report_and_stop();
    end
endmodule : tb
